// ===== core/idp_core.sv
// Indirect data pointers with virtual access locations, AXI4-Lite slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "idp_consts.svh"

module idp_core import idp_pkg::*; #(
    parameter int AW = `IDP_ADDR_W
) (
    input logic clk_sys, // 40 MHz core clock
    input logic rst, // Asynchronous reset, active high
    input logic ce, // Clock enable, freezes all state when low
    input logic [AW-1:0] s_axi_awaddr, // Write address
    input logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input logic [31:0] s_axi_wdata, // Write data
    input logic [3:0] s_axi_wstrb, // Write strobes
    input logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input logic s_axi_bready, // Write response ready
    input logic [AW-1:0] s_axi_araddr, // Read address
    input logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input logic s_axi_rready // Read data ready
);

    localparam int DEPTH = 1 << `IDP_PTR_W;

    // ============================================================
    // Decode helpers

    // Virtual location lookup
    function automatic idp_dec_t idp_decode(input logic [`IDP_IDX_W-1:0] idx);
        idp_dec_t d;
        d = '{ind: 1'b0, sel: 2'd0, kind: IDP_PLAIN};
        if (idx == `IDP_IDX_PLAIN0) d = '{1'b1, 2'd0, IDP_PLAIN};
        else if (idx == `IDP_IDX_INC0) d = '{1'b1, 2'd0, IDP_POST_INCREMENT_LOCATION};
        else if (idx == `IDP_IDX_DEC0) d = '{1'b1, 2'd0, IDP_POST_DECREMENT_LOCATION};
        else if (idx == `IDP_IDX_PRE0) d = '{1'b1, 2'd0, IDP_PRE_INCREMENT_LOCATION};
        else if (idx == `IDP_IDX_OFF0) d = '{1'b1, 2'd0, IDP_OFFSET};
        else if (idx == `IDP_IDX_PLAIN1) d = '{1'b1, 2'd1, IDP_PLAIN};
        else if (idx == `IDP_IDX_INC1) d = '{1'b1, 2'd1, IDP_POST_INCREMENT_LOCATION};
        else if (idx == `IDP_IDX_DEC1) d = '{1'b1, 2'd1, IDP_POST_DECREMENT_LOCATION};
        else if (idx == `IDP_IDX_PRE1) d = '{1'b1, 2'd1, IDP_PRE_INCREMENT_LOCATION};
        else if (idx == `IDP_IDX_OFF1) d = '{1'b1, 2'd1, IDP_OFFSET};
        else if (idx == `IDP_IDX_PLAIN2) d = '{1'b1, 2'd2, IDP_PLAIN};
        else if (idx == `IDP_IDX_INC2) d = '{1'b1, 2'd2, IDP_POST_INCREMENT_LOCATION};
        else if (idx == `IDP_IDX_DEC2) d = '{1'b1, 2'd2, IDP_POST_DECREMENT_LOCATION};
        else if (idx == `IDP_IDX_PRE2) d = '{1'b1, 2'd2, IDP_PRE_INCREMENT_LOCATION};
        else if (idx == `IDP_IDX_OFF2) d = '{1'b1, 2'd2, IDP_OFFSET};
        return d;
    endfunction: idp_decode

    // Physical register lookup
    function automatic logic idp_is_reg(input logic [`IDP_IDX_W-1:0] idx);
        logic r;
        r = 1'b0;
        if (idx == `IDP_IDX_LOW0 || idx == `IDP_IDX_HIGH0) r = 1'b1;
        else if (idx == `IDP_IDX_LOW1 || idx == `IDP_IDX_HIGH1) r = 1'b1;
        else if (idx == `IDP_IDX_LOW2 || idx == `IDP_IDX_HIGH2) r = 1'b1;
        else if (idx == `IDP_IDX_WORKING_REGISTER || idx == `IDP_IDX_BANK) r = 1'b1;
        return r;
    endfunction: idp_is_reg

    // Memory address reached by a virtual location
    function automatic logic [`IDP_PTR_W-1:0] idp_target(
        input idp_kind_t kind,
        input logic [`IDP_PTR_W-1:0] ptr,
        input logic [7:0] w
    );
        logic [`IDP_PTR_W-1:0] a;
        a = ptr;
        case (kind)
            IDP_PRE_INCREMENT_LOCATION: a = ptr + `IDP_STEP;
            IDP_OFFSET: a = ptr + {{`IDP_HI_W{w[7]}}, w};
            default: a = ptr;
        endcase
        return a;
    endfunction: idp_target

    // Pointer value after the access
    function automatic logic [`IDP_PTR_W-1:0] idp_step(
        input idp_kind_t kind,
        input logic [`IDP_PTR_W-1:0] ptr
    );
        logic [`IDP_PTR_W-1:0] n;
        n = ptr;
        case (kind)
            IDP_POST_INCREMENT_LOCATION: n = ptr + `IDP_STEP;
            IDP_PRE_INCREMENT_LOCATION: n = ptr + `IDP_STEP;
            IDP_POST_DECREMENT_LOCATION: n = ptr - `IDP_STEP;
            default: n = ptr;
        endcase
        return n;
    endfunction: idp_step

    // ============================================================
    // State

    logic [`IDP_PTR_W-1:0] ptr_r [0:2];
    logic [7:0] working_register_r;
    logic [`IDP_BANK_W-1:0] bank_r;
    logic [7:0] dmem [DEPTH];
    logic aw_full_r;
    logic [`IDP_IDX_W-1:0] awidx_r;
    logic w_full_r;
    idp_wbeat_t wbeat_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // ============================================================
    // Access selection

    logic wr_go;
    logic rd_go;
    logic acc_wr;
    logic [`IDP_IDX_W-1:0] acc_idx;
    idp_dec_t dec;
    logic [`IDP_PTR_W-1:0] cur_ptr;
    logic [`IDP_PTR_W-1:0] tgt;
    logic miss;
    logic [7:0] rd_val;

    // One access per cycle; a pending write beats a new read
    assign wr_go = ce && aw_full_r && w_full_r && !bvalid_r;
    assign s_axi_arready = ce && !rvalid_r && !(aw_full_r && w_full_r && !bvalid_r);
    assign s_axi_awready = ce && !aw_full_r;
    assign s_axi_wready = ce && !w_full_r;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    // Disabled byte lane 0 means no access, so pointers do not move
    assign acc_wr = wr_go && wbeat_r.strb;
    assign acc_idx = rd_go ? s_axi_araddr[AW-1:2] : awidx_r;
    assign dec = idp_decode(acc_idx);
    assign cur_ptr = ptr_r[dec.sel];
    assign tgt = idp_target(dec.kind, cur_ptr, working_register_r);
    assign miss = !dec.ind && !idp_is_reg(acc_idx);

    // Read value of the addressed location
    always_comb begin
        rd_val = 8'h00;
        if (dec.ind) begin
            rd_val = dmem[tgt];
        end else if (acc_idx == `IDP_IDX_LOW0) begin
            rd_val = ptr_r[0][7:0];
        end else if (acc_idx == `IDP_IDX_HIGH0) begin
            rd_val = {4'h0, ptr_r[0][`IDP_PTR_W-1:`IDP_LOW_W]};
        end else if (acc_idx == `IDP_IDX_LOW1) begin
            rd_val = ptr_r[1][7:0];
        end else if (acc_idx == `IDP_IDX_HIGH1) begin
            rd_val = {4'h0, ptr_r[1][`IDP_PTR_W-1:`IDP_LOW_W]};
        end else if (acc_idx == `IDP_IDX_LOW2) begin
            rd_val = ptr_r[2][7:0];
        end else if (acc_idx == `IDP_IDX_HIGH2) begin
            rd_val = {4'h0, ptr_r[2][`IDP_PTR_W-1:`IDP_LOW_W]};
        end else if (acc_idx == `IDP_IDX_WORKING_REGISTER) begin
            rd_val = working_register_r;
        end else if (acc_idx == `IDP_IDX_BANK) begin
            rd_val = {4'h0, bank_r};
        end
    end

    // ============================================================
    // Pointers

    // Reset to zero so simulation never sees unknown addresses
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                ptr_r[i] <= `IDP_PTR_RST;
            end
        end else if (ce) begin
            if ((rd_go || acc_wr) && dec.ind) begin
                ptr_r[dec.sel] <= idp_step(dec.kind, cur_ptr);
            end else if (acc_wr) begin
                if (acc_idx == `IDP_IDX_LOW0) ptr_r[0][7:0] <= wbeat_r.data;
                else if (acc_idx == `IDP_IDX_HIGH0)
                    ptr_r[0][`IDP_PTR_W-1:`IDP_LOW_W] <= wbeat_r.data[3:0];
                else if (acc_idx == `IDP_IDX_LOW1) ptr_r[1][7:0] <= wbeat_r.data;
                else if (acc_idx == `IDP_IDX_HIGH1)
                    ptr_r[1][`IDP_PTR_W-1:`IDP_LOW_W] <= wbeat_r.data[3:0];
                else if (acc_idx == `IDP_IDX_LOW2) ptr_r[2][7:0] <= wbeat_r.data;
                else if (acc_idx == `IDP_IDX_HIGH2)
                    ptr_r[2][`IDP_PTR_W-1:`IDP_LOW_W] <= wbeat_r.data[3:0];
            end
        end
    end

    // Working register and bank select
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            working_register_r <= `IDP_WORKING_REGISTER_RST;
            bank_r <= `IDP_BANK_RST;
        end else if (ce && acc_wr) begin
            if (acc_idx == `IDP_IDX_WORKING_REGISTER) working_register_r <= wbeat_r.data;
            else if (acc_idx == `IDP_IDX_BANK) bank_r <= wbeat_r.data[3:0];
        end
    end

    // ============================================================
    // Data memory; no reset, contents are whatever software left

    always_ff @(posedge clk_sys) begin
        if (ce && acc_wr && dec.ind) begin
            dmem[tgt] <= wbeat_r.data;
        end
    end

    // ============================================================
    // Write channel: address and data taken in either order

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_full_r <= 1'b0;
            awidx_r <= '0;
            w_full_r <= 1'b0;
            wbeat_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= `IDP_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awidx_r <= s_axi_awaddr[AW-1:2];
            end else if (wr_go) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wbeat_r <= '{data: s_axi_wdata[7:0], strb: s_axi_wstrb[0]};
            end else if (wr_go) begin
                w_full_r <= 1'b0;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= miss ? `IDP_RESP_SLVERR : `IDP_RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ============================================================
    // Read channel: data registered one cycle after the address

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `IDP_RESP_OKAY;
        end else if (ce) begin
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rdata_r <= {24'h000000, rd_val};
                rresp_r <= miss ? `IDP_RESP_SLVERR : `IDP_RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ============================================================
    // Checks; helpers compute expected bytes independently

    logic [`IDP_PTR_W-1:0] p0;
    logic [`IDP_PTR_W-1:0] p1;
    logic [`IDP_PTR_W-1:0] p2;
    logic [`IDP_HI_W-1:0] p0_hi;
    logic [7:0] chk_p1;
    logic [7:0] chk_off0;
    logic [7:0] chk_off2;
    logic [7:0] chk_pre2;
    logic [7:0] chk_wdat;
    assign p0 = ptr_r[0];
    assign p1 = ptr_r[1];
    assign p2 = ptr_r[2];
    assign p0_hi = p0[`IDP_PTR_W-1:`IDP_LOW_W];
    assign chk_p1 = dmem[p1];
    assign chk_off0 = dmem[p0 + {{`IDP_HI_W{working_register_r[7]}}, working_register_r}];
    assign chk_off2 = dmem[p2 + {{`IDP_HI_W{working_register_r[7]}}, working_register_r}];
    assign chk_pre2 = dmem[p2 + `IDP_STEP];
    assign chk_wdat = wbeat_r.data;

    property p_plain1_read;
        @(posedge clk_sys) disable iff (rst)
        rd_go && acc_idx == `IDP_IDX_PLAIN1 |=>
            s_axi_rvalid && s_axi_rdata[7:0] == $past(chk_p1);
    endproperty
    a_plain1_read: assert property (p_plain1_read)
        else $error("plain pointer-1 read returned wrong byte");

    property p_plain1_keep;
        @(posedge clk_sys) disable iff (rst)
        (rd_go || acc_wr) && acc_idx == `IDP_IDX_PLAIN1 |=> p1 == $past(p1);
    endproperty
    a_plain1_keep: assert property (p_plain1_keep)
        else $error("plain pointer-1 access moved the pointer");

    property p_off0_read;
        @(posedge clk_sys) disable iff (rst)
        rd_go && acc_idx == `IDP_IDX_OFF0 |=>
            s_axi_rdata[7:0] == $past(chk_off0) && p0 == $past(p0);
    endproperty
    a_off0_read: assert property (p_off0_read)
        else $error("pointer-0 offset read wrong");

    property p_low0_write;
        @(posedge clk_sys) disable iff (rst)
        acc_wr && acc_idx == `IDP_IDX_LOW0 |=> p0[7:0] == $past(chk_wdat);
    endproperty
    a_low0_write: assert property (p_low0_write)
        else $error("pointer-0 low byte not written");

    property p_high0_read;
        @(posedge clk_sys) disable iff (rst)
        rd_go && acc_idx == `IDP_IDX_HIGH0 |=>
            s_axi_rdata[31:4] == 28'h0000000 && s_axi_rdata[3:0] == $past(p0_hi);
    endproperty
    a_high0_read: assert property (p_high0_read)
        else $error("pointer-0 high nibble read wrong");

    property p_off2_read;
        @(posedge clk_sys) disable iff (rst)
        rd_go && acc_idx == `IDP_IDX_OFF2 |=>
            s_axi_rdata[7:0] == $past(chk_off2) && p2 == $past(p2);
    endproperty
    a_off2_read: assert property (p_off2_read)
        else $error("pointer-2 offset read wrong");

    property p_inc0_step;
        @(posedge clk_sys) disable iff (rst)
        (rd_go || acc_wr) && acc_idx == `IDP_IDX_INC0 |=> p0 == $past(p0) + `IDP_STEP;
    endproperty
    a_inc0_step: assert property (p_inc0_step)
        else $error("post-increment did not step pointer 0");

    property p_dec1_step;
        @(posedge clk_sys) disable iff (rst)
        (rd_go || acc_wr) && acc_idx == `IDP_IDX_DEC1 |=> p1 == $past(p1) - `IDP_STEP;
    endproperty
    a_dec1_step: assert property (p_dec1_step)
        else $error("post-decrement did not step pointer 1");

    property p_pre2_read;
        @(posedge clk_sys) disable iff (rst)
        rd_go && acc_idx == `IDP_IDX_PRE2 |=> s_axi_rdata[7:0] == $past(chk_pre2);
    endproperty
    a_pre2_read: assert property (p_pre2_read)
        else $error("pre-increment read used stale pointer");

endmodule: idp_core

// ===== core/idp_consts.svh
// Register indices, widths and reset values of the indirect pointer block
`ifndef IDP_CONSTS_SVH
`define IDP_CONSTS_SVH
// ============================================================
// Register indices; byte address on the bus is index times four
`define IDP_IDX_LOW2 12'hfd9
`define IDP_IDX_HIGH2 12'hfda
`define IDP_IDX_OFF2 12'hfdb
`define IDP_IDX_PRE2 12'hfdc
`define IDP_IDX_DEC2 12'hfdd
`define IDP_IDX_INC2 12'hfde
`define IDP_IDX_PLAIN2 12'hfdf
`define IDP_IDX_BANK 12'hfe0
`define IDP_IDX_LOW1 12'hfe1
`define IDP_IDX_HIGH1 12'hfe2
`define IDP_IDX_OFF1 12'hfe3
`define IDP_IDX_PRE1 12'hfe4
`define IDP_IDX_DEC1 12'hfe5
`define IDP_IDX_INC1 12'hfe6
`define IDP_IDX_PLAIN1 12'hfe7
`define IDP_IDX_WORKING_REGISTER 12'hfe8
`define IDP_IDX_LOW0 12'hfe9
`define IDP_IDX_HIGH0 12'hfea
`define IDP_IDX_OFF0 12'hfeb
`define IDP_IDX_PRE0 12'hfec
`define IDP_IDX_DEC0 12'hfed
`define IDP_IDX_INC0 12'hfee
`define IDP_IDX_PLAIN0 12'hfef
// ============================================================
// Widths
`define IDP_IDX_W 12
`define IDP_ADDR_W 14
`define IDP_PTR_W 12
`define IDP_LOW_W 8
`define IDP_HI_W 4
`define IDP_BANK_W 4
// ============================================================
// Reset values, responses and pointer step
`define IDP_PTR_RST 12'h000
`define IDP_WORKING_REGISTER_RST 8'h00
`define IDP_BANK_RST 4'h0
`define IDP_RESP_OKAY 2'b00
`define IDP_RESP_SLVERR 2'b10
`define IDP_STEP 12'h001
`endif

// ===== core/idp_pkg.sv
// Types shared by the indirect pointer block
package idp_pkg;
    // ============================================================
    // How a virtual location moves its pointer
    typedef enum logic [2:0] {
        IDP_PLAIN,
        IDP_POST_INCREMENT_LOCATION,
        IDP_POST_DECREMENT_LOCATION,
        IDP_PRE_INCREMENT_LOCATION,
        IDP_OFFSET
    } idp_kind_t;

    // Decoded virtual location
    typedef struct packed {
        logic ind;
        logic [1:0] sel;
        idp_kind_t kind;
    } idp_dec_t;

    // Held write beat
    typedef struct packed {
        logic [7:0] data;
        logic strb;
    } idp_wbeat_t;
endpackage: idp_pkg

// ===== tb/idp_bus_master.sv
// Register-bus master model standing in for the core's instruction execution
`timescale 1ns/1ps
module idp_bus_master (
    input logic clk_sys, // Core clock
    output logic [13:0] awaddr, // Write address
    output logic awvalid, // Write address valid
    input logic awready, // Write address ready
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Write strobes
    output logic wvalid, // Write data valid
    input logic wready, // Write data ready
    input logic [1:0] bresp, // Write response
    input logic bvalid, // Write response valid
    output logic bready, // Write response ready
    output logic [13:0] araddr, // Read address
    output logic arvalid, // Read address valid
    input logic arready, // Read address ready
    input logic [31:0] rdata, // Read data
    input logic [1:0] rresp, // Read response
    input logic rvalid, // Read data valid
    output logic rready // Read data ready
);
    // ============================================================
    // Idle bus; ready for answers at all times
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
        bready = 1'b1;
        rready = 1'b1;
    end

    // ============================================================
    // One write: address and data offered together, each released when taken
    task automatic write_word(input logic [11:0] idx, input logic [7:0] d, input logic strb,
                              output logic [1:0] resp);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= {3'b000, strb};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        fork
            begin
                do @(posedge clk_sys); while (awready !== 1'b1);
                awvalid <= 1'b0;
                // Released payload flips so a stale value is never mistaken for live
                awaddr <= ~awaddr;
            end
            begin
                do @(posedge clk_sys); while (wready !== 1'b1);
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        join
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        resp = bresp;
    endtask: write_word

    // ============================================================
    // One read, data taken at the edge where the answer is seen
    task automatic read_word(input logic [11:0] idx, output logic [31:0] d,
                             output logic [1:0] resp);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~araddr;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
    endtask: read_word
endmodule: idp_bus_master

// ===== tb/test_indirect_data_pointers.sv
// Self-checking bench for the indirect data pointer block
`timescale 1ns/1ps
`include "idp_consts.svh"
module test_indirect_data_pointers;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] ptr_m [3];
    logic [7:0] mem_m [4096];
    logic [7:0] working_register_m = 8'h00;
    logic [3:0] bank_m = 4'h0;
    logic [11:0] regs [8] = '{12'hfd9, 12'hfda, 12'hfe0, 12'hfe1, 12'hfe2, 12'hfe8, 12'hfe9,
                              12'hfea};
    int errors = 0;
    int cmp_count = 0;
    int seed = 13664;

    always #12.5 clk_sys = ~clk_sys;

    // Random clock-enable stalls; held high while an answer is due, so no handshake freezes
    always @(posedge clk_sys) begin
        ce <= (($random(seed) & 3) != 0) || bvalid || rvalid || i_dut.wr_go ||
              (arvalid && arready);
    end

    idp_core i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    idp_bus_master i_mst (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ============================================================
    // Comparison and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask: check

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask: final_report

    // ============================================================
    // One bus access, predicted by the reference model and compared
    task automatic acc(input logic [11:0] idx, input logic wr, input logic [7:0] d,
                       input logic strb);
        logic [1:0] resp;
        logic [31:0] got;
        logic [1:0] exp_r;
        logic [7:0] exp_d;
        logic [11:0] a;
        int p;
        int k;
        exp_r = `IDP_RESP_OKAY;
        exp_d = 8'h00;
        // Group layout: low, high, offset, pre-inc, post-dec, post-inc, plain
        p = (idx >= `IDP_IDX_LOW0) ? 0 : (idx >= `IDP_IDX_LOW1) ? 1 : 2;
        k = idx - ((p == 0) ? `IDP_IDX_LOW0 : (p == 1) ? `IDP_IDX_LOW1 : `IDP_IDX_LOW2);
        if (wr) i_mst.write_word(idx, d, strb, resp);
        else i_mst.read_word(idx, got, resp);
        if (idx < `IDP_IDX_LOW2 || idx > `IDP_IDX_PLAIN0) exp_r = `IDP_RESP_SLVERR;
        else if (idx == `IDP_IDX_BANK) begin
            if (wr && strb) bank_m = d[3:0];
            exp_d = {4'h0, bank_m};
        end else if (idx == `IDP_IDX_WORKING_REGISTER) begin
            if (wr && strb) working_register_m = d;
            exp_d = working_register_m;
        end else if (k == 0) begin
            if (wr && strb) ptr_m[p][7:0] = d;
            exp_d = ptr_m[p][7:0];
        end else if (k == 1) begin
            if (wr && strb) ptr_m[p][11:8] = d[3:0];
            exp_d = {4'h0, ptr_m[p][11:8]};
        end else if (!wr || strb) begin
            // Signed offset from the working register; pointers wrap at 4096
            a = ptr_m[p] + ((k == 3) ? 12'h001 : 12'h000);
            if (k == 2) a = ptr_m[p] + {{4{working_register_m[7]}}, working_register_m};
            if (k == 3) ptr_m[p] = a;
            if (k == 4) ptr_m[p] = ptr_m[p] - 12'h001;
            if (k == 5) ptr_m[p] = ptr_m[p] + 12'h001;
            if (wr) mem_m[a] = d;
            exp_d = mem_m[a];
        end
        check({30'h0, resp}, {30'h0, exp_r});
        if (!wr) check(got, {24'h000000, exp_d});
    endtask: acc

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        acc(idx, 1'b1, d, 1'b1);
    endtask: wr

    task automatic rd(input logic [11:0] idx);
        acc(idx, 1'b0, 8'h00, 1'b1);
    endtask: rd

    // ============================================================
    // Watchdog, well beyond the expected 16k cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        final_report();
    end

    // ============================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 3; i++) ptr_m[i] = `IDP_PTR_RST;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (regs[i]) rd(regs[i]);
        wr(`IDP_IDX_HIGH0, 8'hff);
        rd(`IDP_IDX_HIGH0);
        wr(`IDP_IDX_HIGH0, 8'h00);
        // Fill all memory through post-increment so later reads are defined
        for (int i = 0; i < 4096; i++) wr(`IDP_IDX_INC0, i[7:0] ^ 8'h5a);
        rd(`IDP_IDX_LOW0);
        wr(`IDP_IDX_LOW1, 8'h34);
        wr(`IDP_IDX_HIGH1, 8'h02);
        wr(`IDP_IDX_PLAIN1, 8'ha5);
        rd(`IDP_IDX_PLAIN1);
        rd(`IDP_IDX_LOW1);
        rd(`IDP_IDX_HIGH1);
        // Most negative offset reaches below the pointer and wraps
        wr(`IDP_IDX_WORKING_REGISTER, 8'h80);
        wr(`IDP_IDX_LOW0, 8'h05);
        rd(`IDP_IDX_OFF0);
        wr(`IDP_IDX_OFF0, 8'h3c);
        rd(`IDP_IDX_OFF0);
        rd(`IDP_IDX_LOW0);
        wr(`IDP_IDX_WORKING_REGISTER, 8'h7f);
        wr(`IDP_IDX_LOW2, 8'hff);
        wr(`IDP_IDX_HIGH2, 8'h0f);
        wr(`IDP_IDX_OFF2, 8'hc3);
        rd(`IDP_IDX_OFF2);
        rd(`IDP_IDX_LOW2);
        wr(`IDP_IDX_LOW2, 8'h00);
        wr(`IDP_IDX_HIGH2, 8'h00);
        rd(`IDP_IDX_DEC2);
        rd(`IDP_IDX_HIGH2);
        rd(`IDP_IDX_PRE2);
        rd(`IDP_IDX_LOW2);
        acc(`IDP_IDX_INC1, 1'b1, 8'h99, 1'b0);
        rd(`IDP_IDX_LOW1);
        wr(12'h000, 8'h11);
        rd(12'hfd8);
        // Random traffic over the whole map and just beyond it
        for (int i = 0; i < 500; i++) begin
            acc(12'hfd8 + 12'($random(seed) & 31), 1'($random(seed)), 8'($random(seed)),
                ($random(seed) & 7) != 0);
        end
        // Reset in mid-run: registers and pointers return to zero, memory keeps its bytes
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) ptr_m[i] = `IDP_PTR_RST;
        working_register_m = `IDP_WORKING_REGISTER_RST;
        bank_m = `IDP_BANK_RST;
        @(posedge clk_sys);
        foreach (regs[i]) rd(regs[i]);
        rd(`IDP_IDX_PLAIN0);
        final_report();
    end
endmodule: test_indirect_data_pointers
